/* File: design/limit_check.sv */
// Upper and lower limit comparison with hysteresis on release
`timescale 1ns/100ps
`default_nettype none
module limit_check #(
  parameter int W = 32
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] sample_in,
  input  wire logic         sample_valid_in,
  input  wire logic         upper_on_in,
  input  wire logic         lower_on_in,
  input  wire logic [W-1:0] upper_level_in,
  input  wire logic [W-1:0] lower_level_in,
  input  wire logic [W-1:0] hyst_in,
  output logic              cond_out
);
  logic         hi_trip_q, hi_trip_d;
  logic         lo_trip_q, lo_trip_d;
  logic [W:0]   s, hi, lo, hy;

  always_comb begin
    s  = {1'b0, sample_in};
    hi = {1'b0, upper_level_in};
    lo = {1'b0, lower_level_in};
    hy = {1'b0, hyst_in};
    hi_trip_d = hi_trip_q;
    lo_trip_d = lo_trip_q;
    if (!upper_on_in) begin
      hi_trip_d = 1'b0;
    end else if (sample_valid_in) begin
      if (s > hi) begin
        hi_trip_d = 1'b1;
      end else if (s + hy < hi) begin
        hi_trip_d = 1'b0;
      end
    end
    if (!lower_on_in) begin
      lo_trip_d = 1'b0;
    end else if (sample_valid_in) begin
      if (s < lo) begin
        lo_trip_d = 1'b1;
      end else if (s > lo + hy) begin
        lo_trip_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hi_trip_q <= 1'b0;
      lo_trip_q <= 1'b0;
    end else begin
      hi_trip_q <= hi_trip_d;
      lo_trip_q <= lo_trip_d;
    end
  end

  assign cond_out = hi_trip_q | lo_trip_q;

  a_upper_trip: assert property (@(posedge core_clk_in) disable iff (rst_in)
    sample_valid_in && upper_on_in && sample_in > upper_level_in
    |=> cond_out) else $error("upper limit not tripped");
  a_lower_trip: assert property (@(posedge core_clk_in) disable iff (rst_in)
    sample_valid_in && lower_on_in && sample_in < lower_level_in
    |=> cond_out) else $error("lower limit not tripped");
  a_hyst_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    hi_trip_q && upper_on_in && sample_valid_in && !lo_trip_q
    && {1'b0, sample_in} + {1'b0, hyst_in} >= {1'b0, upper_level_in}
    |=> cond_out) else $error("trip released inside margin");
endmodule : limit_check
`default_nettype wire

/* File: design/peak_tracker.sv */
// Largest ion current within a small mass window around the selected mass
`timescale 1ns/100ps
`default_nettype none
`include "relay_limit_regs.svh"
module peak_tracker
  import relay_limit_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic [8:0]                sel_mass_in,
  input  wire relay_limit_pkg::mass_pos_t pos_in,
  input  wire logic [W-1:0]              current_in,
  input  wire logic                      valid_in,
  input  wire logic                      scan_end_in,
  output logic [W-1:0]                   peak_out,
  output logic                           peak_valid_out
);
  peak_state_e  state_q, state_d;
  logic [W-1:0] peak_q, peak_d, max_q, max_d;
  logic         pv_q, pv_d;
  logic [12:0]  center, pos, lo_edge, hi_edge;
  logic         in_win, past_win;

  always_comb begin
    center   = 13'({sel_mass_in, 3'h0} + {2'h0, sel_mass_in, 1'h0});
    pos      = {1'b0, pos_in};
    lo_edge  = center - {1'b0, `RLM_MASS_WIN};
    hi_edge  = center + {1'b0, `RLM_MASS_WIN};
    in_win   = valid_in && pos >= lo_edge && pos <= hi_edge;
    past_win = (valid_in && pos > hi_edge) || scan_end_in;
    state_d  = state_q;
    peak_d   = peak_q;
    max_d    = max_q;
    pv_d     = 1'b0;
    case (state_q)
      PEAK_IDLE: begin
        if (sel_mass_in != 9'h000 && in_win) begin
          state_d = PEAK_IN;
          max_d   = current_in;
        end
      end
      PEAK_IN: begin
        if (sel_mass_in == 9'h000) begin
          state_d = PEAK_IDLE;
        end else if (in_win) begin
          if (current_in > max_q) begin
            max_d = current_in;
          end
        end else if (past_win) begin
          state_d = PEAK_IDLE;
          peak_d  = max_q;
          pv_d    = 1'b1;
        end
      end
      default: state_d = PEAK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_q <= PEAK_IDLE;
      peak_q  <= '0;
      max_q   <= '0;
      pv_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      peak_q  <= peak_d;
      max_q   <= max_d;
      pv_q    <= pv_d;
    end
  end

  assign peak_out       = peak_q;
  assign peak_valid_out = pv_q;

  a_zero_mass_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in)
    sel_mass_in == 9'h000 |=> !peak_valid_out)
    else $error("reading produced for mass zero");
  a_peak_is_max: assert property (@(posedge core_clk_in) disable iff (rst_in)
    state_q == PEAK_IN && in_win && sel_mass_in != 9'h000
    |=> max_q >= $past(current_in)) else $error("peak below sample");
endmodule : peak_tracker
`default_nettype wire

/* File: design/relay_limit_monitor.sv */
// Relay limit monitor: register slave, limit checks and relay drive
`timescale 1ns/100ps
`default_nettype none
`include "relay_limit_regs.svh"
module relay_limit_monitor
  import relay_limit_pkg::*;
#(
  parameter int VW = 32,
  parameter int MW = 32
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  input  wire logic [5:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [5:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [VW-1:0]             analog_voltage_in,
  input  wire logic                      analog_voltage_valid_in,
  input  wire relay_limit_pkg::mass_pos_t mass_pos_in,
  input  wire logic [MW-1:0]             ion_current_in,
  input  wire logic                      ion_current_valid_in,
  input  wire logic                      scan_end_in,
  output logic                           relay_out,
  output logic                           irq_out
);
  // Configuration
  logic [7:0]    ctrl_q, ctrl_d;
  logic [VW-1:0] v_hi_q, v_hi_d, v_lo_q, v_lo_d, v_hy_q, v_hy_d;
  logic [MW-1:0] m_hi_q, m_hi_d, m_lo_q, m_lo_d, m_hy_q, m_hy_d;
  logic [8:0]    msel_q, msel_d;
  logic [2:0]    ist_q, ist_d, imask_q, imask_d;
  // Bus slave
  logic          aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [5:0]    awaddr_q, awaddr_d;
  logic [31:0]   wdata_q, wdata_d;
  logic [3:0]    wstrb_q, wstrb_d;
  logic          bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]   rdata_q, rdata_d;
  logic [31:0]   wmerge, rword;
  logic          do_write, rd_hit;
  // Monitoring
  logic          relay_q, relay_d, v_cond_q, m_cond_q, m_cond_d;
  logic          v_cond, m_cond_raw, m_peak_vld, ev_any;
  logic [MW-1:0] m_peak;
  force_e        force_mode;

  peak_tracker #(.W(MW)) u_peak (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .sel_mass_in    (msel_q),
    .pos_in         (mass_pos_in),
    .current_in     (ion_current_in),
    .valid_in       (ion_current_valid_in),
    .scan_end_in    (scan_end_in),
    .peak_out       (m_peak),
    .peak_valid_out (m_peak_vld)
  );

  limit_check #(.W(VW)) u_volt (
    .core_clk_in     (core_clk_in),
    .rst_in          (rst_in),
    .sample_in       (analog_voltage_in),
    .sample_valid_in (analog_voltage_valid_in),
    .upper_on_in     (ctrl_q[`RLM_CTRL_V_UP]),
    .lower_on_in     (ctrl_q[`RLM_CTRL_V_LO]),
    .upper_level_in  (v_hi_q),
    .lower_level_in  (v_lo_q),
    .hyst_in         (v_hy_q),
    .cond_out        (v_cond)
  );

  // Mass limits see only committed window peaks, never raw samples
  limit_check #(.W(MW)) u_mass (
    .core_clk_in     (core_clk_in),
    .rst_in          (rst_in),
    .sample_in       (m_peak),
    .sample_valid_in (m_peak_vld),
    .upper_on_in     (ctrl_q[`RLM_CTRL_M_UP]),
    .lower_on_in     (ctrl_q[`RLM_CTRL_M_LO]),
    .upper_level_in  (m_hi_q),
    .lower_level_in  (m_lo_q),
    .hyst_in         (m_hy_q),
    .cond_out        (m_cond_raw)
  );

  // Bus slave: one write and one read in flight; address and data in any order
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    do_write = aw_full_q && w_full_q && !bvalid_q;
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      // Unaligned offsets are unmapped, so the answer matches the read side
      bresp_d   = (awaddr_q > `RLM_OFF_INT_MASK || awaddr_q[1:0] != 2'h0)
                  ? `RLM_RESP_SLVERR : `RLM_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : 8'h00;
    end
  end

  // Register file; hardware-set interrupt bits win over a software clear
  always_comb begin
    ctrl_d  = ctrl_q;
    v_hi_d  = v_hi_q;
    v_lo_d  = v_lo_q;
    v_hy_d  = v_hy_q;
    m_hi_d  = m_hi_q;
    m_lo_d  = m_lo_q;
    m_hy_d  = m_hy_q;
    msel_d  = msel_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    if (do_write) begin
      case (awaddr_q)
        `RLM_OFF_CTRL:      ctrl_d  = wmerge[7:0];
        `RLM_OFF_VOLT_HI:   v_hi_d  = VW'(wmerge);
        `RLM_OFF_VOLT_LO:   v_lo_d  = VW'(wmerge);
        `RLM_OFF_VOLT_HYST: v_hy_d  = VW'(wmerge);
        `RLM_OFF_MASS_HI:   m_hi_d  = MW'(wmerge);
        `RLM_OFF_MASS_LO:   m_lo_d  = MW'(wmerge);
        `RLM_OFF_MASS_HYST: m_hy_d  = MW'(wmerge);
        `RLM_OFF_MASS_SEL:  msel_d  = wmerge[8:0];
        `RLM_OFF_INT_STAT:  ist_d   = ist_q & ~wmerge[2:0];
        `RLM_OFF_INT_MASK:  imask_d = wmerge[2:0];
        default: ;
      endcase
    end
    ist_d[`RLM_INT_V_TRIP]    = ist_d[`RLM_INT_V_TRIP] | (v_cond & ~v_cond_q);
    ist_d[`RLM_INT_M_TRIP]    = ist_d[`RLM_INT_M_TRIP] | (m_cond_d & ~m_cond_q);
    ist_d[`RLM_INT_RELAY_CHG] = ist_d[`RLM_INT_RELAY_CHG] | (relay_d ^ relay_q);
  end

  // Read path
  always_comb begin
    rd_hit = 1'b1;
    rword  = 32'h0000_0000;
    case (s_axi_araddr)
      `RLM_OFF_CTRL:      rword = {24'h00_0000, ctrl_q};
      `RLM_OFF_VOLT_HI:   rword = 32'(v_hi_q);
      `RLM_OFF_VOLT_LO:   rword = 32'(v_lo_q);
      `RLM_OFF_VOLT_HYST: rword = 32'(v_hy_q);
      `RLM_OFF_MASS_HI:   rword = 32'(m_hi_q);
      `RLM_OFF_MASS_LO:   rword = 32'(m_lo_q);
      `RLM_OFF_MASS_HYST: rword = 32'(m_hy_q);
      `RLM_OFF_MASS_SEL:  rword = {23'h00_0000, msel_q};
      `RLM_OFF_STATUS:    rword = {29'h0000_0000, m_cond_q, v_cond_q, relay_q};
      `RLM_OFF_MASS_READ: rword = 32'(m_peak);
      `RLM_OFF_INT_STAT:  rword = {29'h0000_0000, ist_q};
      `RLM_OFF_INT_MASK:  rword = {29'h0000_0000, imask_q};
      default:            rd_hit = 1'b0;
    endcase
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rword;
      rresp_d  = rd_hit ? `RLM_RESP_OKAY : `RLM_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Relay: any enabled event condition, unless software forces the position
  always_comb begin
    force_mode = force_e'(ctrl_q[`RLM_CTRL_FORCE_MSB:`RLM_CTRL_FORCE_LSB]);
    // Mass zero means nothing is checked, so a stale trip must not linger
    m_cond_d = m_cond_raw && msel_q != 9'h000;
    ev_any   = (v_cond && ctrl_q[`RLM_CTRL_V_EVT])
             || (m_cond_d && ctrl_q[`RLM_CTRL_M_EVT]);
    case (force_mode)
      FORCE_ON:  relay_d = 1'b1;
      FORCE_OFF: relay_d = 1'b0;
      default:   relay_d = ev_any;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_q    <= `RLM_CTRL_RST;
      v_hi_q    <= VW'(`RLM_LEVEL_RST);
      v_lo_q    <= VW'(`RLM_LEVEL_RST);
      v_hy_q    <= VW'(`RLM_LEVEL_RST);
      m_hi_q    <= MW'(`RLM_LEVEL_RST);
      m_lo_q    <= MW'(`RLM_LEVEL_RST);
      m_hy_q    <= MW'(`RLM_LEVEL_RST);
      msel_q    <= 9'h000;
      ist_q     <= 3'h0;
      imask_q   <= `RLM_MASK_RST;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 6'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
      relay_q   <= 1'b0;
      v_cond_q  <= 1'b0;
      m_cond_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      v_hi_q    <= v_hi_d;
      v_lo_q    <= v_lo_d;
      v_hy_q    <= v_hy_d;
      m_hi_q    <= m_hi_d;
      m_lo_q    <= m_lo_d;
      m_hy_q    <= m_hy_d;
      msel_q    <= msel_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      relay_q   <= relay_d;
      v_cond_q  <= v_cond;
      m_cond_q  <= m_cond_d;
    end
  end

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign relay_out     = relay_q;
  assign irq_out       = |(ist_q & imask_q);

  sequence s_volt_over;
    analog_voltage_valid_in && ctrl_q[`RLM_CTRL_V_UP]
    && ctrl_q[`RLM_CTRL_V_EVT] && force_mode == FORCE_AUTO
    && analog_voltage_in > v_hi_q;
  endsequence
  sequence s_volt_under;
    analog_voltage_valid_in && ctrl_q[`RLM_CTRL_V_LO]
    && ctrl_q[`RLM_CTRL_V_EVT] && force_mode == FORCE_AUTO
    && analog_voltage_in < v_lo_q;
  endsequence

  a_volt_hi_relay: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_volt_over ##1 $stable(ctrl_q) |=> relay_out)
    else $error("relay off after voltage over limit");
  a_volt_lo_relay: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_volt_under ##1 $stable(ctrl_q) |=> relay_out)
    else $error("relay off after voltage under limit");
  a_force_wins: assert property (@(posedge core_clk_in) disable iff (rst_in)
    force_mode == FORCE_ON |=> relay_out)
    else $error("forced on but relay off");
  a_force_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    force_mode == FORCE_OFF |=> !relay_out)
    else $error("forced off but relay on");
  a_relay_status: assert property (@(posedge core_clk_in) disable iff (rst_in)
    force_mode == FORCE_AUTO |=> relay_out == $past(ev_any))
    else $error("relay disagrees with event state");
  a_mass_hi_relay: assert property (@(posedge core_clk_in) disable iff (rst_in)
    m_peak_vld && m_peak > m_hi_q && ctrl_q[`RLM_CTRL_M_UP]
    && ctrl_q[`RLM_CTRL_M_EVT] && msel_q != 9'h000 && $stable(ctrl_q)
    && force_mode == FORCE_AUTO ##1 $stable(ctrl_q) && $stable(msel_q)
    |=> relay_out) else $error("relay off after mass over limit");
  a_irq_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
    irq_out == |(ist_q & imask_q))
    else $error("interrupt output disagrees with status");
  a_relay_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    relay_q != $past(relay_q) |-> ist_q[`RLM_INT_RELAY_CHG])
    else $error("relay change not flagged");
endmodule : relay_limit_monitor
`default_nettype wire

/* File: design/relay_limit_pkg.sv */
// Types shared by the relay limit monitor
package relay_limit_pkg;
  typedef enum logic [1:0] {
    FORCE_AUTO = 2'h0,
    FORCE_OFF  = 2'h1,
    FORCE_ON   = 2'h2,
    FORCE_RSVD = 2'h3
  } force_e;

  typedef enum logic [0:0] {
    PEAK_IDLE  = 1'h0,
    PEAK_IN    = 1'h1
  } peak_state_e;

  typedef logic [11:0] mass_pos_t;
endpackage : relay_limit_pkg

/* File: design/relay_limit_regs.svh */
// Register offsets, field positions and reset values of the relay limit monitor
`ifndef RELAY_LIMIT_REGS_SVH
`define RELAY_LIMIT_REGS_SVH

`define RLM_OFF_CTRL       6'h00
`define RLM_OFF_VOLT_HI    6'h04
`define RLM_OFF_VOLT_LO    6'h08
`define RLM_OFF_VOLT_HYST  6'h0c
`define RLM_OFF_MASS_HI    6'h10
`define RLM_OFF_MASS_LO    6'h14
`define RLM_OFF_MASS_HYST  6'h18
`define RLM_OFF_MASS_SEL   6'h1c
`define RLM_OFF_STATUS     6'h20
`define RLM_OFF_MASS_READ  6'h24
`define RLM_OFF_INT_STAT   6'h28
`define RLM_OFF_INT_MASK   6'h2c

`define RLM_CTRL_V_UP      0
`define RLM_CTRL_V_LO      1
`define RLM_CTRL_M_UP      2
`define RLM_CTRL_M_LO      3
`define RLM_CTRL_V_EVT     4
`define RLM_CTRL_M_EVT     5
`define RLM_CTRL_FORCE_LSB 6
`define RLM_CTRL_FORCE_MSB 7

`define RLM_ST_RELAY       0
`define RLM_ST_V_COND      1
`define RLM_ST_M_COND      2

`define RLM_INT_V_TRIP     0
`define RLM_INT_M_TRIP     1
`define RLM_INT_RELAY_CHG  2

`define RLM_CTRL_RST       8'h00
`define RLM_LEVEL_RST      32'h0000_0000
`define RLM_MASK_RST       3'h0

`define RLM_MASS_SCALE     12'h00a
`define RLM_MASS_WIN       12'h003

`define RLM_RESP_OKAY      2'h0
`define RLM_RESP_SLVERR    2'h2

`endif

/* File: testbench/meas_source.sv */
// Measurement sources: voltage samples and mass sweeps
`timescale 1ns/100ps
`default_nettype none
module meas_source (
  input  wire logic        core_clk_in,
  output logic [31:0]      volt_out       = 32'h0,
  output logic             volt_valid_out = 1'b0,
  output logic [11:0]      pos_out        = 12'h000,
  output logic [31:0]      cur_out        = 32'h0,
  output logic             cur_valid_out  = 1'b0,
  output logic             scan_end_out   = 1'b0
);
  task automatic send_volt(input logic [31:0] v);
    volt_out       <= v;
    volt_valid_out <= 1'b1;
    @(posedge core_clk_in);
    // Stale data is inverted so a late sample cannot pass by luck
    volt_out       <= ~v;
    volt_valid_out <= 1'b0;
  endtask : send_volt

  // Peak at the centre; samples just outside the window are larger
  task automatic sweep(input int sel, input logic [31:0] pk);
    for (int d = -6; d <= 6; d++) begin
      pos_out       <= 12'(sel * 10 + d);
      cur_out       <= (d == 0) ? pk : (d >= -3 && d <= 3) ? pk >> 1 : pk + 500;
      cur_valid_out <= 1'b1;
      @(posedge core_clk_in);
    end
    cur_valid_out <= 1'b0;
    cur_out       <= ~pk;
    scan_end_out  <= 1'b1;
    @(posedge core_clk_in);
    scan_end_out  <= 1'b0;
  endtask : sweep
endmodule : meas_source
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench of the relay limit monitor
`timescale 1ns/100ps
`default_nettype none
`include "relay_limit_regs.svh"
module tb_top;
  import relay_limit_pkg::*;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic [5:0]  awaddr  = 6'h00;
  logic [5:0]  araddr  = 6'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        vvalid, cvalid, send, relay, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, vin, cur, hi, lo, hy, pk, v, r;
  mass_pos_t   pos;
  logic        ut      = 1'b0;
  logic        lt      = 1'b0;
  int          fails = 0, compares = 0, seed = 58490;
  logic [31:0] vu[5];
  logic [31:0] vl[4];

  always #4 clk = ~clk;

  relay_limit_monitor u_relay_limit_monitor (
    .core_clk_in(clk), .rst_in(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .analog_voltage_in(vin), .analog_voltage_valid_in(vvalid),
    .mass_pos_in(pos), .ion_current_in(cur), .ion_current_valid_in(cvalid),
    .scan_end_in(send), .relay_out(relay), .irq_out(irq));

  meas_source u_meas_source (
    .core_clk_in(clk), .volt_out(vin), .volt_valid_out(vvalid),
    .pos_out(pos), .cur_out(cur), .cur_valid_out(cvalid),
    .scan_end_out(send));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp(32'(bresp), 32'(er));
    // One idle edge so the next call never re-raises bready in this step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp(rdata, exp);
    cmp(32'(rresp), 32'(er));
    @(posedge clk);
  endtask : rd

  // Expected trip state; release needs the full hysteresis margin
  function automatic logic nxt(input logic t, input logic [31:0] x,
                               input logic [31:0] lim, input logic up);
    if (up) return t ? !(x + hy < lim) : (x > lim);
    return t ? !(x > lim + hy) : (x < lim);
  endfunction : nxt

  task automatic volt(input logic [31:0] x, input logic [7:0] c);
    ut = c[0] ? nxt(ut, x, hi, 1'b1) : 1'b0;
    lt = c[1] ? nxt(lt, x, lo, 1'b0) : 1'b0;
    u_meas_source.send_volt(x);
    @(posedge clk);
    @(negedge clk);
    cmp(32'(relay), 32'(ut | lt));
    @(posedge clk);
  endtask : volt

  task automatic mass_check(input logic [31:0] exp);
    u_meas_source.sweep(5, pk);
    repeat (6) @(posedge clk);
    cmp(32'(relay), exp);
  endtask : mass_check

  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin : watchdog
    #200000;
    fails++;
    final_report();
  end

  initial begin : main
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp(32'(relay), 32'h0);
    rd(`RLM_OFF_CTRL, 32'h0, 2'h0);
    hi = 32'h3e8 + ($random(seed) & 32'hff);
    lo = 32'hc8 + ($random(seed) & 32'h3f);
    hy = 32'h1 + ($random(seed) & 32'hf);
    wr(`RLM_OFF_VOLT_HI, hi, 2'h0);
    wr(`RLM_OFF_VOLT_LO, lo, 2'h0);
    wr(`RLM_OFF_VOLT_HYST, hy, 2'h0);
    rd(`RLM_OFF_VOLT_HYST, hy, 2'h0);
    wr(`RLM_OFF_CTRL, 32'h02, 2'h0);
    rd(`RLM_OFF_CTRL, 32'h02, 2'h0);
    wr(`RLM_OFF_CTRL, 32'h11, 2'h0);
    vu = '{hi, hi + 32'h1, hi - hy, hi - hy - 32'h1, hi + 32'h1};
    foreach (vu[i]) volt(vu[i], 8'h11);
    cmp(32'(irq), 32'h0);
    wr(`RLM_OFF_INT_MASK, 32'h1, 2'h0);
    cmp(32'(irq), 32'h1);
    wr(`RLM_OFF_INT_STAT, 32'h5, 2'h0);
    cmp(32'(irq), 32'h0);
    rd(`RLM_OFF_INT_STAT, 32'h0, 2'h0);
    // Force off with a met condition, then every force code without one
    wr(`RLM_OFF_CTRL, 32'h51, 2'h0);
    repeat (3) @(posedge clk);
    cmp(32'(relay), 32'h0);
    for (int f = 0; f < 4; f++) begin
      wr(`RLM_OFF_CTRL, 32'(f * 64 + 16), 2'h0);
      repeat (3) @(posedge clk);
      cmp(32'(relay), 32'(f == 2));
    end
    ut = 1'b0;
    wr(`RLM_OFF_CTRL, 32'h12, 2'h0);
    vl = '{lo, lo - 32'h1, lo + hy, lo + hy + 32'h1};
    foreach (vl[i]) volt(vl[i], 8'h12);
    wr(`RLM_OFF_CTRL, 32'h13, 2'h0);
    repeat (16) begin
      r = $random(seed);
      v = r[8] ? hi - 32'h18 + (r & 32'h1f) : lo - 32'h8 + (r & 32'h1f);
      volt(v, 8'h13);
    end
    pk = 32'h1388 + ($random(seed) & 32'h3ff);
    wr(`RLM_OFF_MASS_SEL, 32'h5, 2'h0);
    wr(`RLM_OFF_MASS_HI, pk - 32'h1, 2'h0);
    wr(`RLM_OFF_CTRL, 32'h24, 2'h0);
    mass_check(32'h1);
    rd(`RLM_OFF_MASS_READ, pk, 2'h0);
    wr(`RLM_OFF_MASS_LO, pk, 2'h0);
    wr(`RLM_OFF_CTRL, 32'h28, 2'h0);
    mass_check(32'h0);
    wr(`RLM_OFF_MASS_LO, pk + 32'h1, 2'h0);
    mass_check(32'h1);
    wr(`RLM_OFF_MASS_SEL, 32'h0, 2'h0);
    u_meas_source.sweep(0, pk);
    repeat (6) @(posedge clk);
    rd(`RLM_OFF_STATUS, 32'h0, 2'h0);
    rd(6'h30, 32'h0, 2'h2);
    wr(6'h31, 32'h1, 2'h2);
    wr(6'h06, 32'h1, 2'h2);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
